// ---- bench/branch_bit_exec_chk.sv ----
// Port-level assertions for the branch and bit-test executor.
// Assumes one clock; bound to every instance of the executor.
`timescale 1ns/1ps
module branch_bit_exec_chk
import branch_bit_pkg::*;
(
	// Clock and reset
	input wire logic            CLOCK,
	input wire logic            SYS_RST,
	// Bus
	input wire logic            HSEL,
	input wire logic [1:0]      HTRANS,
	input wire logic            HREADY,
	input wire logic [31:0]     HRDATA,
	input wire logic            HREADYOUT,
	input wire logic            HRESP,
	// Execution
	input wire logic [PC_W-1:0] PC_OUT,
	input wire logic            BUSY
);
	logic [3:0] run_q;
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (SYS_RST);
	// Length of busy, so its fall lands on whole cycles
	always_ff @(posedge CLOCK or posedge SYS_RST)
	begin
		if (SYS_RST)
			run_q <= 4'h0;
		else
			run_q <= BUSY ? run_q + 4'h1 : 4'h0;
	end
	property p_resp; HRESP == 1'b0; endproperty
	a_resp: assert property (p_resp) else $error("error response");
	property p_wait;
		HSEL && HTRANS[1] && HREADY |=> !HREADYOUT ##1 HREADYOUT;
	endproperty
	a_wait: assert property (p_wait) else $error("wait state wrong");
	property p_idle; !(HSEL && HTRANS[1]) && HREADYOUT |=> HREADYOUT; endproperty
	a_idle: assert property (p_idle) else $error("stall without transfer");
	property p_rdata; $changed(HRDATA) |-> !$past(HREADYOUT); endproperty
	a_rdata: assert property (p_rdata) else $error("read data moved");
	property p_start; $rose(BUSY) |-> !$past(HREADYOUT); endproperty
	a_start: assert property (p_start) else $error("busy without write");
	property p_len; $rose(BUSY) |-> BUSY [*4]; endproperty
	a_len: assert property (p_len) else $error("cycle too short");
	property p_quad;
		$fell(BUSY) |-> run_q != 4'h0 && run_q[1:0] == 2'h0 && run_q <= 4'hc;
	endproperty
	a_quad: assert property (p_quad) else $error("bad cycle count");
	property p_pc; $changed(PC_OUT) |-> $past(BUSY) || !$past(HREADYOUT);
	endproperty
	a_pc: assert property (p_pc) else $error("counter moved idle");
endmodule
bind branch_bit_exec branch_bit_exec_chk i_chk (.CLOCK, .SYS_RST, .HSEL,
	.HTRANS, .HREADY, .HRDATA, .HREADYOUT, .HRESP, .PC_OUT, .BUSY);

// ---- bench/branch_bit_exec_tb.sv ----
// Self-checking bench for the branch and bit-test executor.
// Acts as the only AHB-Lite master; HREADY is fed from HREADYOUT.
`timescale 1ns/1ps
module branch_bit_exec_tb
import branch_bit_pkg::*;
;
	logic            clk = 1'b0;
	logic            rst = 1'b1;
	logic [1:0]      htrans = 2'h0;
	logic [31:0]     haddr = 32'h0;
	logic            hwrite = 1'b0;
	logic [31:0]     hwdata = 32'h0;
	logic [31:0]     hrdata;
	logic            hready;
	logic            hresp;
	logic [PC_W-1:0] pc_out;
	logic            busy;
	int              error_cnt = 0;
	int              n_compared = 0;
	int              cyc = 0;
	logic [31:0]     sts;

	always #5 clk = ~clk;

	branch_bit_exec i_branch_bit_exec (.CLOCK(clk), .SYS_RST(rst),
		.HSEL(1'b1), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
		.HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata),
		.HREADYOUT(hready), .HRESP(hresp), .PC_OUT(pc_out), .BUSY(busy));

	task automatic final_report;
		$display("Compared %0d, mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("BAD at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Called right after an edge; waits on ready, the timeout ends a hang
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r);
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		do @(posedge clk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hready !== 1'b1);
		r = hrdata;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		bus(1'b1, a, d, r);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] r);
		bus(1'b0, a, 32'h0, r);
	endtask

	task automatic run(input logic [15:0] ins, input logic [20:0] pc0,
		input logic [4:0] fl, input logic [20:0] pce, input logic [1:0] cy);
		logic [31:0] r;
		wr(OFS_PC, {11'h0, pc0});
		wr(OFS_FLAGS, {27'h0, fl});
		wr(OFS_INSTR, {16'h0, ins});
		r = 32'h1;
		for (int i = 0; i < 20 && r[STS_BUSY] !== 1'b0; i++)
			rd(OFS_STATUS, r);
		sts = r;
		chk({31'h0, r[STS_BUSY]}, 32'h0);
		chk({30'h0, r[9:8]}, {30'h0, cy});
		chk({11'h0, pc_out}, {11'h0, pce});
		chk({31'h0, busy}, 32'h0);
		chk({31'h0, hresp}, 32'h0);
		rd(OFS_PC, r);
		chk(r, {11'h0, pce});
		rd(OFS_FLAGS, r);
		chk(r, {27'h0, fl});
	endtask

	task automatic mem(input logic [31:0] c, m, d0, input logic [15:0] ins,
		input logic [20:0] pce, input logic [1:0] cy, input logic [31:0] de);
		logic [31:0] r;
		wr(OFS_CTRL, c);
		wr(OFS_INDEX_BASE, 32'h200);
		wr(OFS_MEM_ADDR, m);
		wr(OFS_MEM_DATA, d0);
		run(ins, 21'h40, 5'h0a, pce, cy);
		rd(OFS_MEM_DATA, r);
		chk(r, de);
	endtask

	task automatic t_reset;
		logic [31:0] r;
		rd(OFS_PC, r);
		chk(r, 32'h0);
		chk({11'h0, pc_out}, 32'h0);
		rd(OFS_STATUS, r);
		chk(r, 32'h0);
		rd(8'h20, r);
		chk(r, 32'h0);
		$display("Test reset done");
	endtask

	// Every other flag set, so a wrong flag choice shows
	task automatic t_branch;
		logic [7:0] op [4] = '{OP_NO_CARRY, OP_NOT_NEG, OP_NO_OVERFLOW,
			OP_NO_ZERO};
		int pos [4] = '{FLG_CARRY, FLG_NEGATIVE, FLG_OVERFLOW, FLG_ZERO};
		logic [4:0] fl;
		for (int i = 0; i < 4; i++)
		begin
			fl = 5'h1f ^ (5'h01 << pos[i]);
			run({op[i], 8'h80}, 21'h1000, fl, 21'h0f02, 2'd2);
			chk({31'h0, sts[STS_TAKEN]}, 32'h1);
			run({op[i], 8'h7f}, 21'h1000, fl, 21'h1100, 2'd2);
			run({op[i], 8'h7f}, 21'h1000, ~fl, 21'h1002, 2'd1);
			chk({31'h0, sts[STS_TAKEN]}, 32'h0);
		end
		run({OP_JUMP_ALWAYS, 11'h400}, 21'h1000, 5'h1f, 21'h0802, 2'd2);
		run({OP_JUMP_ALWAYS, 11'h3ff}, 21'h1000, 5'h00, 21'h1800, 2'd2);
		chk({31'h0, sts[STS_TAKEN]}, 32'h1);
		// Opcode outside the group: one cycle, PC steps on, flagged
		run(16'h0000, 21'h1000, 5'h00, 21'h1002, 2'd1);
		chk({31'h0, sts[STS_ILLEGAL]}, 32'h1);
		$display("Test branches done");
	endtask

	task automatic t_bits;
		logic [15:0] sc;
		logic [15:0] ss;
		sc = {OP_SKIP_CLEAR, 3'd2, 1'b0, 8'h70};
		ss = {OP_SKIP_SET, 3'd2, 1'b0, 8'h70};
		mem(32'h300, 32'h3a5, 32'h0a, {OP_SET_BIT, 3'd7, 1'b1, 8'ha5},
			21'h42, 2'd1, 32'h8a);
		mem(32'h0, 32'hf60, 32'h0, {OP_SET_BIT, 3'd0, 1'b0, 8'h60},
			21'h42, 2'd1, 32'h01);
		mem(32'h0, 32'h030, 32'h10, {OP_SET_BIT, 3'd1, 1'b0, 8'h30},
			21'h42, 2'd1, 32'h12);
		mem(32'h1, 32'h25f, 32'h0, {OP_SET_BIT, 3'd3, 1'b0, 8'h5f},
			21'h42, 2'd1, 32'h08);
		mem(32'h0, 32'hf70, 32'h00, sc, 21'h44, 2'd2, 32'h00);
		chk({31'h0, sts[STS_SKIPPED]}, 32'h1);
		mem(32'h2, 32'hf70, 32'h00, sc, 21'h46, 2'd3, 32'h00);
		mem(32'h0, 32'hf70, 32'h04, sc, 21'h42, 2'd1, 32'h04);
		chk({31'h0, sts[STS_SKIPPED]}, 32'h0);
		mem(32'h0, 32'hf70, 32'h04, ss, 21'h44, 2'd2, 32'h04);
		mem(32'h2, 32'hf70, 32'hfb, ss, 21'h42, 2'd1, 32'hfb);
		mem(32'h2, 32'hf70, 32'h04, ss, 21'h46, 2'd3, 32'h04);
		$display("Test bit ops done");
	endtask

	// Ceiling well above the several hundred cycles the tests need
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 8000)
		begin
			error_cnt++;
			final_report;
		end
	end

	initial
	begin
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_reset;
		t_branch;
		t_bits;
		final_report;
	end
endmodule

// ---- design/branch_bit_exec.sv ----
// Executor for status branches, relative jump, bit set and bit test-skip.
// Assumes an AHB-Lite master on CLOCK; one instruction cycle is 4 clocks.
//
// What this block does
// - No-carry branch jumps only when carry clear
// - Not-negative branch jumps only when negative clear
// - No-overflow branch jumps only when overflow clear
// - Not-zero branch jumps only when zero clear
// - Branch offset is signed low byte
// - Taken target is address plus two plus 2n
// - Branch: one cycle, or two when taken
// - Jump always: 11-bit offset, two cycles
// - Bit set: read, set bit, write back
// - Skip when selected bit is clear
// - Skip when selected bit is set
// - Test: one, two or three cycles
// - Access flag picks access bank or bank
// - Extended mode indexes addresses up to 95
// - Eight-bit file address, three-bit bit position
//
// The register offsets and the AHB-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
module branch_bit_exec
(
	// Clock and reset
	input  wire logic                         CLOCK,
	input  wire logic                         SYS_RST,
	// AHB-Lite slave
	input  wire logic                         HSEL,
	input  wire logic [31:0]                  HADDR,
	input  wire logic [1:0]                   HTRANS,
	input  wire logic                         HWRITE,
	input  wire logic [2:0]                   HSIZE,
	input  wire logic [31:0]                  HWDATA,
	input  wire logic                         HREADY,
	output logic      [31:0]                  HRDATA,
	output logic                              HREADYOUT,
	output logic                              HRESP,
	// Execution state
	output logic      [branch_bit_pkg::PC_W-1:0] PC_OUT,
	output logic                              BUSY
);
	import branch_bit_pkg::*;

	typedef struct packed
	{
		logic [31:0]       hrdata;
		logic              hready;
		logic              hresp;
		logic              dphase;
		logic              dwrite;
		logic              dword;
		logic [7:0]        daddr;
		logic [15:0]       instr;
		logic [PC_W-1:0]   pc;
		logic [4:0]        flags;
		logic              ext_en;
		logic              two_word;
		logic [3:0]        bank;
		logic [ADDR_W-1:0] index_base;
		logic [ADDR_W-1:0] mem_addr;
		state_t            state;
		logic [1:0]        phase;
		logic [1:0]        extra;
		logic              taken;
		logic              skipped;
		logic              illegal;
		logic [1:0]        cycles;
		logic              busy;
	} regs_t;

	regs_t             r_q;
	regs_t             r_d;
	logic [ADDR_W-1:0] m_addr;
	logic              m_we;
	logic [7:0]        m_wdata;
	logic [7:0]        m_rdata;

	// Effective data address of a bit-oriented instruction
	function automatic logic [ADDR_W-1:0] eff_addr
	(
		input logic [15:0]       ins,
		input logic              ext,
		input logic [3:0]        bank,
		input logic [ADDR_W-1:0] base
	);
		logic [7:0] f;
		f = ins[7:0];
		if (ins[8])
			eff_addr = {bank, f};
		else if (ext && f <= ACCESS_LOW_MAX)
			eff_addr = ADDR_W'(base + {4'h0, f});
		else if (f <= ACCESS_LOW_MAX)
			eff_addr = {4'h0, f};
		else
			eff_addr = {SFR_BANK, f};
	endfunction

	// Target of a taken relative branch from an 11-bit signed offset
	function automatic logic [PC_W-1:0] rel_target
	(
		input logic [PC_W-1:0] pc,
		input logic [10:0]     off
	);
		rel_target = PC_W'(pc + PC_STEP1 + {{9{off[10]}}, off, 1'b0});
	endfunction

	file_memory
	#(
		.ADDR_W (ADDR_W),
		.DATA_W (8)
	)
	u_mem
	(
		.clk     (CLOCK),
		.addr    (m_addr),
		.wr_en   (m_we),
		.wr_data (m_wdata),
		.rd_data (m_rdata)
	);

	always_comb
	begin
		logic              accept;
		logic              idle;
		logic              flag;
		logic              bitv;
		logic [7:0]        upper;
		logic [2:0]        bpos;
		logic [ADDR_W-1:0] ea;
		logic [31:0]       rdv;
		accept  = HSEL && HTRANS[1] && HREADY;
		idle    = (r_q.state == ST_IDLE);
		upper   = r_q.instr[15:8];
		bpos    = r_q.instr[11:9];
		ea      = eff_addr(r_q.instr, r_q.ext_en, r_q.bank, r_q.index_base);
		bitv    = m_rdata[bpos];
		flag    = 1'b0;
		rdv     = 32'h00000000;
		r_d     = r_q;
		m_addr  = idle ? r_q.mem_addr : ea;
		m_we    = 1'b0;
		m_wdata = 8'h00;

		// Bus address phase; one wait state keeps HRDATA registered
		if (accept)
		begin
			r_d.dphase = 1'b1;
			r_d.dwrite = HWRITE;
			r_d.dword  = (HSIZE == 3'h2);
			r_d.daddr  = HADDR[7:0];
			r_d.hready = 1'b0;
		end
		if (r_q.dphase)
		begin
			r_d.dphase = 1'b0;
			r_d.hready = 1'b1;
			if (!r_q.dwrite)
			begin
				unique case (r_q.daddr)
					OFS_INSTR:      rdv = {16'h0000, r_q.instr};
					OFS_PC:         rdv = {11'h000, r_q.pc};
					OFS_FLAGS:      rdv = {27'h0000000, r_q.flags};
					OFS_CTRL:       rdv = {20'h00000, r_q.bank, 6'h00,
						r_q.two_word, r_q.ext_en};
					OFS_INDEX_BASE: rdv = {20'h00000, r_q.index_base};
					OFS_STATUS:     rdv = {22'h000000, r_q.cycles, 4'h0,
						r_q.illegal, r_q.skipped, r_q.taken, !idle};
					OFS_MEM_ADDR:   rdv = {20'h00000, r_q.mem_addr};
					OFS_MEM_DATA:   rdv = {24'h000000, m_rdata};
					default:        rdv = 32'h00000000;
				endcase
				r_d.hrdata = rdv;
			end
			else if (r_q.dword)
			begin
				// Instruction, PC and memory-data writes are dropped while an instruction runs
				unique case (r_q.daddr)
					OFS_INSTR:
						if (idle)
						begin
							r_d.instr = HWDATA[15:0];
							r_d.state = ST_EXEC;
							r_d.phase = 2'h0;
						end
					OFS_PC:
						if (idle)
							r_d.pc = HWDATA[PC_W-1:0];
					OFS_FLAGS:      r_d.flags = HWDATA[4:0];
					OFS_CTRL:
					begin
						r_d.ext_en   = HWDATA[CTL_EXT_EN];
						r_d.two_word = HWDATA[CTL_TWO_WORD];
						r_d.bank     = HWDATA[CTL_BANK_LSB +: 4];
					end
					OFS_INDEX_BASE: r_d.index_base = HWDATA[ADDR_W-1:0];
					OFS_MEM_ADDR:   r_d.mem_addr = HWDATA[ADDR_W-1:0];
					OFS_MEM_DATA:
						if (idle)
						begin
							m_we    = 1'b1;
							m_wdata = HWDATA[7:0];
						end
					default:        r_d.hresp = 1'b0;
				endcase
			end
		end

		// Execution: Q1 decode/address, Q2 read, Q3 process, Q4 write
		unique case (r_q.state)
			ST_IDLE:
				r_d.phase = r_d.phase;
			ST_EXEC:
			begin
				r_d.phase = 2'(r_q.phase + 2'h1);
				if (r_q.phase == LAST_PHASE)
				begin
					r_d.taken   = 1'b0;
					r_d.skipped = 1'b0;
					r_d.illegal = 1'b0;
					r_d.extra   = 2'h0;
					r_d.pc      = PC_W'(r_q.pc + PC_STEP1);
					if (upper == OP_NO_CARRY || upper == OP_NOT_NEG ||
						upper == OP_NO_OVERFLOW || upper == OP_NO_ZERO)
					begin
						unique case (upper)
							OP_NO_CARRY:    flag = r_q.flags[FLG_CARRY];
							OP_NOT_NEG:     flag = r_q.flags[FLG_NEGATIVE];
							OP_NO_OVERFLOW: flag = r_q.flags[FLG_OVERFLOW];
							default:        flag = r_q.flags[FLG_ZERO];
						endcase
						if (!flag)
						begin
							r_d.taken = 1'b1;
							r_d.extra = 2'h1;
							r_d.pc    = rel_target(r_q.pc,
								{{3{r_q.instr[7]}}, r_q.instr[7:0]});
						end
					end
					else if (r_q.instr[15:11] == OP_JUMP_ALWAYS)
					begin
						r_d.taken = 1'b1;
						r_d.extra = 2'h1;
						r_d.pc    = rel_target(r_q.pc, r_q.instr[10:0]);
					end
					else if (r_q.instr[15:12] == OP_SET_BIT)
					begin
						m_we    = 1'b1;
						m_wdata = m_rdata | (8'h01 << bpos);
					end
					else if (r_q.instr[15:12] == OP_SKIP_SET ||
						r_q.instr[15:12] == OP_SKIP_CLEAR)
					begin
						if ((r_q.instr[15:12] == OP_SKIP_CLEAR && !bitv) ||
							(r_q.instr[15:12] == OP_SKIP_SET && bitv))
						begin
							r_d.skipped = 1'b1;
							r_d.extra   = r_q.two_word ? 2'h2 : 2'h1;
							r_d.pc      = PC_W'(r_q.pc + (r_q.two_word ?
								PC_STEP3 : PC_STEP2));
						end
					end
					else
						r_d.illegal = 1'b1;
					r_d.cycles = 2'(r_d.extra + 2'h1);
					r_d.state  = (r_d.extra == 2'h0) ? ST_IDLE : ST_FLUSH;
				end
			end
			ST_FLUSH:
			begin
				// Discarded prefetch: idle cycles, flags untouched
				r_d.phase = 2'(r_q.phase + 2'h1);
				if (r_q.phase == LAST_PHASE)
				begin
					r_d.extra = 2'(r_q.extra - 2'h1);
					if (r_q.extra == 2'h1)
						r_d.state = ST_IDLE;
				end
			end
			default:
				r_d.state = ST_IDLE;
		endcase
		// Kept in a flop so BUSY leaves the block glitch-free
		r_d.busy = (r_d.state != ST_IDLE);
	end

	always_ff @(posedge CLOCK or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			r_q            <= '0;
			r_q.hready     <= 1'b1;
			r_q.instr      <= INSTR_RST;
			r_q.pc         <= PC_RST;
			r_q.flags      <= FLAGS_RST;
			r_q.bank       <= BANK_RST;
			r_q.state      <= ST_IDLE;
		end
		else
			r_q <= r_d;
	end

	assign HRDATA    = r_q.hrdata;
	assign HREADYOUT = r_q.hready;
	assign HRESP     = r_q.hresp;
	assign PC_OUT    = r_q.pc;
	assign BUSY      = r_q.busy;
endmodule

// ---- design/file_memory.sv ----
// Byte-wide data memory with one shared port and a registered read.
// Assumes the owner keeps address stable for a cycle before using data.
`timescale 1ns/1ps
module file_memory
#(
	parameter int ADDR_W = 12,
	parameter int DATA_W = 8
)
(
	// Clock
	input  wire logic              clk,
	// Port
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic              wr_en,
	input  wire logic [DATA_W-1:0] wr_data,
	output logic      [DATA_W-1:0] rd_data
);
	typedef struct packed
	{
		logic [DATA_W-1:0] rdata;
	} mem_regs_t;

	logic [DATA_W-1:0] cells [0:(1<<ADDR_W)-1];
	mem_regs_t         r_q;
	mem_regs_t         r_d;

	always_comb
	begin
		r_d       = r_q;
		r_d.rdata = cells[addr];
	end

	// No reset: contents are software-initialised
	always_ff @(posedge clk)
	begin
		r_q <= r_d;
		if (wr_en)
		begin
			cells[addr] <= wr_data;
		end
	end

	assign rd_data = r_q.rdata;
endmodule

// ---- shared/branch_bit_pkg.sv ----
// Constants, types and register map of the branch and bit-test executor.
// Assumes a 32-bit AHB-Lite slave on one clock; 16-bit instruction words.
package branch_bit_pkg;

	// Register byte offsets
	localparam logic [7:0] OFS_INSTR      = 8'h00;
	localparam logic [7:0] OFS_PC         = 8'h04;
	localparam logic [7:0] OFS_FLAGS      = 8'h08;
	localparam logic [7:0] OFS_CTRL       = 8'h0c;
	localparam logic [7:0] OFS_INDEX_BASE = 8'h10;
	localparam logic [7:0] OFS_STATUS     = 8'h14;
	localparam logic [7:0] OFS_MEM_ADDR   = 8'h18;
	localparam logic [7:0] OFS_MEM_DATA   = 8'h1c;

	// Flag register bit positions
	localparam int FLG_CARRY    = 0;
	localparam int FLG_ZERO     = 2;
	localparam int FLG_OVERFLOW = 3;
	localparam int FLG_NEGATIVE = 4;

	// Control register fields
	localparam int CTL_EXT_EN   = 0;
	localparam int CTL_TWO_WORD = 1;
	localparam int CTL_BANK_LSB = 8;

	// Status register fields
	localparam int STS_BUSY       = 0;
	localparam int STS_TAKEN      = 1;
	localparam int STS_SKIPPED    = 2;
	localparam int STS_ILLEGAL    = 3;
	localparam int STS_CYCLES_LSB = 8;

	// Widths and reset values
	localparam int PC_W   = 21;
	localparam int ADDR_W = 12;
	localparam logic [15:0] INSTR_RST = 16'h0000;
	localparam logic [20:0] PC_RST    = 21'h000000;
	localparam logic [4:0]  FLAGS_RST = 5'h00;
	localparam logic [3:0]  BANK_RST  = 4'h0;

	// Opcode fields
	localparam logic [7:0] OP_NO_ZERO     = 8'he1;
	localparam logic [7:0] OP_NO_CARRY    = 8'he3;
	localparam logic [7:0] OP_NO_OVERFLOW = 8'he5;
	localparam logic [7:0] OP_NOT_NEG     = 8'he7;
	localparam logic [4:0] OP_JUMP_ALWAYS = 5'h1a;
	localparam logic [3:0] OP_SET_BIT     = 4'h8;
	localparam logic [3:0] OP_SKIP_SET    = 4'ha;
	localparam logic [3:0] OP_SKIP_CLEAR  = 4'hb;

	// Addressing boundaries
	localparam logic [7:0] ACCESS_LOW_MAX = 8'h5f;
	localparam logic [3:0] SFR_BANK       = 4'hf;

	// Timing: core clocks per instruction cycle, and PC steps
	localparam logic [1:0]  LAST_PHASE = 2'h3;
	localparam logic [20:0] PC_STEP1   = 21'h000002;
	localparam logic [20:0] PC_STEP2   = 21'h000004;
	localparam logic [20:0] PC_STEP3   = 21'h000006;

	typedef enum logic [1:0]
	{
		ST_IDLE  = 2'b00,
		ST_EXEC  = 2'b01,
		ST_FLUSH = 2'b10
	} state_t;

endpackage
